// ==== core/prtrx_pkg.sv ====
/*
 * constants shared by both ends of the printer parallel byte link:
 * link timing, cycle counts, switch bit positions and buffer sizes.
 * assumes a single 200 MHz controller clock on each end.
 */
package prtrx_pkg;

	// ----------------------------------------------------------------
	// clock and link timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned STROBE_MIN_NS = 500;
	localparam int unsigned ACK_PULSE_NS = 5000;
	localparam int unsigned INIT_MIN_NS = 50000;
	localparam int unsigned DATA_SETUP_NS = 500;
	localparam int unsigned MAX_CPS = 1000;
	localparam int unsigned NS_PER_S = 1000000000;

	// "more than" a least time: round up, then one cycle extra
	localparam int unsigned STROBE_CYC =
		(STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int unsigned ACK_CYC = ACK_PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned INIT_CYC =
		(INIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int unsigned SETUP_CYC =
		(DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BYTE_CYC =
		(NS_PER_S / MAX_CPS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// switch bit positions (bit set means switch on)
	// ----------------------------------------------------------------
	localparam int unsigned SW1_CR_PRINT = 1;
	localparam int unsigned SW1_FULL_PRINT = 2;
	localparam int unsigned SW1_CAN_OFF = 3;
	localparam int unsigned SW1_DEL_OFF = 4;
	localparam int unsigned SW1_BUZZ = 5;
	localparam int unsigned SW1_SEL_FIX = 7;
	localparam int unsigned SW2_FORM12 = 0;
	localparam int unsigned SW2_SPACE8 = 1;
	localparam int unsigned SW2_AUTO_FIX = 2;
	localparam int unsigned SW2_PERF = 3;

	// ----------------------------------------------------------------
	// sizes and reset values
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned CNT_W = 18;
	localparam int unsigned SYNC_W = 25;
	localparam logic [SYNC_W-1:0] SYNC_RST = 25'h1ffffff;

endpackage

// ==== core/prtrx_if.sv ====
/*
 * pin bundle between the host adapter end and the printer end.
 * assumes all pins are one-way; levels follow the link, not logic.
 */
`timescale 1ns/100ps
interface prtrx_if;
	logic strobe_n;
	logic [7:0] data;
	logic ack_n;
	logic busy;
	logic paper_out;
	logic selected_status;
	logic error_n;
	logic auto_feed_n;
	logic init_n;
	logic select_input_n;

	modport device (
		input strobe_n, data, auto_feed_n, init_n, select_input_n,
		output ack_n, busy, paper_out, selected_status, error_n
	);
	modport host (
		output strobe_n, data, auto_feed_n, init_n, select_input_n,
		input ack_n, busy, paper_out, selected_status, error_n
	);
endinterface

// ==== core/prtrx_fifo.sv ====
/*
 * synchronous fifo with valid/ready on both sides and a clear.
 * assumes one clock; clock enable low freezes everything except reset.
 */
`timescale 1ns/100ps
module prtrx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic clr_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire do_wr = in_valid_i & in_ready_o;
	wire do_rd = out_valid_o & out_ready_i;

	// honest flags straight from the fill count
	assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem[rd_r];

	// storage; no reset needed, guarded by count
	always_ff @(posedge clk_i)
	begin
		if (ce_i && do_wr)
			mem[wr_r] <= in_data_i;
	end

	// pointers and fill count
	always_ff @(posedge clk_i)
	begin
		if (rst_i || (ce_i && clr_i))
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else if (ce_i)
		begin
			if (do_wr)
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (do_rd)
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule

// ==== core/prtrx_dev.sv ====
/*
 * printer end of the parallel byte link: takes strobed bytes into a
 * buffer, answers with acknowledge, reports busy, paper, select and
 * error, and decodes the configuration switches.
 * assumes host pins and switches are asynchronous; engine status
 * inputs and the byte drain side run on CLK_I.
 */
`timescale 1ns/100ps
module prtrx_dev #(
	parameter int DEPTH = prtrx_pkg::FIFO_DEPTH
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic CE_I,
	prtrx_if.device PAR_IF,
	input wire logic [7:0] SW1_I,
	input wire logic [3:0] SW2_I,
	input wire logic GFX_MODEL_I,
	input wire logic PAPER_EMPTY_I,
	input wire logic ONLINE_I,
	input wire logic FAULT_I,
	input wire logic PRINTING_I,
	output logic [7:0] BYTE_DATA_O,
	output logic BYTE_VALID_O,
	input wire logic BYTE_READY_I,
	output logic CLEAR_O,
	output logic CR_LF_O,
	output logic FULL_LF_O,
	output logic CANCEL_EN_O,
	output logic DELETE_EN_O,
	output logic BUZZER_EN_O,
	output logic AUTO_LF_O,
	output logic FORM_12IN_O,
	output logic SPACE_8LPI_O,
	output logic PERF_SKIP_O
);
	typedef enum logic [1:0] {
		DS_IDLE, DS_TAKE, DS_ACK, DS_REL
	} prtrx_dstate_type;

	// ----------------------------------------------------------------
	// two-stage synchroniser for every asynchronous input
	// ----------------------------------------------------------------
	logic [prtrx_pkg::SYNC_W-1:0] meta_r;
	logic [prtrx_pkg::SYNC_W-1:0] sync_r;
	wire [prtrx_pkg::SYNC_W-1:0] pin_raw = {
		PAR_IF.strobe_n, PAR_IF.data, PAR_IF.auto_feed_n,
		PAR_IF.init_n, PAR_IF.select_input_n, SW1_I, SW2_I,
		GFX_MODEL_I};

	// only sync_r is read; meta_r feeds nothing else
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			meta_r <= prtrx_pkg::SYNC_RST;
			sync_r <= prtrx_pkg::SYNC_RST;
		end
		else if (CE_I)
		begin
			meta_r <= pin_raw;
			sync_r <= meta_r;
		end
	end

	// unpack the synchronised bundle
	wire strobe_s = sync_r[24];
	wire [7:0] data_s = sync_r[23:16];
	wire auto_s = sync_r[15];
	wire init_s = sync_r[14];
	wire selin_s = sync_r[13];
	wire [7:0] sw1_s = sync_r[12:5];
	wire [3:0] sw2_s = sync_r[4:1];
	wire gfx_s = sync_r[0];

	// ----------------------------------------------------------------
	// conditions
	// ----------------------------------------------------------------
	logic strobe_d_r;
	prtrx_dstate_type state_r;
	prtrx_dstate_type state_nxt;
	logic [9:0] ack_cnt_r;
	logic [7:0] byte_r;
	logic fifo_ready;
	logic fifo_valid;

	// init low resets the controller and empties the buffer
	wire init_hit = ~init_s;
	// select forced low by switch, else taken from the pin
	wire sel_low = sw1_s[prtrx_pkg::SW1_SEL_FIX] | ~selin_s;
	wire selected = ONLINE_I & sel_low;
	wire err_cond = PAPER_EMPTY_I | ~ONLINE_I | FAULT_I;
	// a full buffer also refuses, so bytes are never dropped
	wire block = PRINTING_I | err_cond | ~fifo_ready | ~sel_low;
	wire strobe_fall = strobe_d_r & ~strobe_s;
	wire ack_done = (ack_cnt_r == '0);
	wire take_push = (state_r == DS_TAKE);

	// ----------------------------------------------------------------
	// byte entry state machine
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			DS_IDLE:
				if (strobe_fall && !block)
					state_nxt = DS_TAKE;
			DS_TAKE:
				if (fifo_ready)
					state_nxt = DS_ACK;
			DS_ACK:
				if (ack_done)
					state_nxt = DS_REL;
			DS_REL:
				if (strobe_s)
					state_nxt = DS_IDLE;
			default:
				state_nxt = DS_IDLE;
		endcase
		if (init_hit)
			state_nxt = DS_IDLE;
	end

	// state, strobe history, captured byte and ack timer
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			state_r <= DS_IDLE;
			strobe_d_r <= 1'b1;
			byte_r <= '0;
			ack_cnt_r <= '0;
		end
		else if (CE_I)
		begin
			state_r <= state_nxt;
			strobe_d_r <= strobe_s;
			if (state_r == DS_IDLE && state_nxt == DS_TAKE)
				byte_r <= data_s;
			if (state_nxt == DS_ACK && state_r != DS_ACK)
				ack_cnt_r <= 10'(prtrx_pkg::ACK_CYC - 1);
			else if (!ack_done)
				ack_cnt_r <= ack_cnt_r - 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// byte buffer toward the print engine
	// ----------------------------------------------------------------
	prtrx_fifo #(
		.WIDTH(prtrx_pkg::DATA_W),
		.DEPTH(DEPTH)
	) prtrx_fifo_i (
		.clk_i(CLK_I),
		.rst_i(SYS_RST_I),
		.ce_i(CE_I),
		.clr_i(init_hit),
		.in_valid_i(take_push),
		.in_ready_o(fifo_ready),
		.in_data_i(byte_r),
		.out_valid_o(fifo_valid),
		.out_ready_i(BYTE_READY_I),
		.out_data_o(BYTE_DATA_O)
	);
	assign BYTE_VALID_O = fifo_valid;

	// ----------------------------------------------------------------
	// link status pins, all from flip-flops
	// ----------------------------------------------------------------
	logic ack_n_r;
	logic busy_r;
	logic pout_r;
	logic selected_status_r;
	logic err_n_r;
	logic clear_r;

	// busy follows the next state so it rises at the strobe fall
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ack_n_r <= 1'b1;
			busy_r <= 1'b1;
			pout_r <= 1'b0;
			selected_status_r <= 1'b0;
			err_n_r <= 1'b0;
			clear_r <= 1'b0;
		end
		else if (CE_I)
		begin
			ack_n_r <= ~(state_nxt == DS_ACK);
			busy_r <= (state_nxt != DS_IDLE) | block;
			pout_r <= PAPER_EMPTY_I;
			selected_status_r <= selected;
			err_n_r <= ~err_cond;
			clear_r <= init_hit;
		end
	end
	assign PAR_IF.ack_n = ack_n_r;
	assign PAR_IF.busy = busy_r;
	assign PAR_IF.paper_out = pout_r;
	assign PAR_IF.selected_status = selected_status_r;
	assign PAR_IF.error_n = err_n_r;
	assign CLEAR_O = clear_r;

	// ----------------------------------------------------------------
	// configuration outputs from the switches
	// ----------------------------------------------------------------
	logic [8:0] cfg_r;
	wire [8:0] cfg_nxt = {
		~sw1_s[prtrx_pkg::SW1_CR_PRINT],
		~sw1_s[prtrx_pkg::SW1_FULL_PRINT],
		~sw1_s[prtrx_pkg::SW1_CAN_OFF],
		~sw1_s[prtrx_pkg::SW1_DEL_OFF],
		sw1_s[prtrx_pkg::SW1_BUZZ],
		sw2_s[prtrx_pkg::SW2_AUTO_FIX] | ~auto_s,
		gfx_s & sw2_s[prtrx_pkg::SW2_FORM12],
		gfx_s & sw2_s[prtrx_pkg::SW2_SPACE8],
		gfx_s & sw2_s[prtrx_pkg::SW2_PERF]};

	// registered so every output changes on a clock edge; switch bounces are not filtered
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
			cfg_r <= '0;
		else if (CE_I)
			cfg_r <= cfg_nxt;
	end
	assign {CR_LF_O, FULL_LF_O, CANCEL_EN_O, DELETE_EN_O, BUZZER_EN_O,
		AUTO_LF_O, FORM_12IN_O, SPACE_8LPI_O, PERF_SKIP_O} = cfg_r;
endmodule

// ==== core/prtrx_host.sv ====
/*
 * host adapter end: presents bytes with a timed strobe, paces them
 * on acknowledge and busy, and drives init, auto feed and select.
 * assumes printer status pins are asynchronous to CLK_I.
 */
`timescale 1ns/100ps
module prtrx_host #(
	parameter int unsigned BYTE_CYC = prtrx_pkg::BYTE_CYC,
	parameter int unsigned INIT_CYC = prtrx_pkg::INIT_CYC
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic CE_I,
	prtrx_if.host PAR_IF,
	input wire logic [7:0] TX_DATA_I,
	input wire logic TX_VALID_I,
	output logic TX_READY_O,
	input wire logic INIT_REQ_I,
	input wire logic AUTO_FEED_I,
	input wire logic SELECT_I,
	output logic BUSY_O,
	output logic PAPER_OUT_O,
	output logic SELECTED_O,
	output logic ERROR_O
);
	localparam int CW = prtrx_pkg::CNT_W;
	typedef enum logic [2:0] {
		HS_IDLE, HS_SETUP, HS_STROBE, HS_WAIT, HS_INIT
	} prtrx_hstate_type;

	// ----------------------------------------------------------------
	// status pin synchroniser
	// ----------------------------------------------------------------
	logic [4:0] meta_r;
	logic [4:0] sync_r;
	logic ack_d_r;
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			// busy reads high until the printer has really said otherwise
			meta_r <= 5'h19;
			sync_r <= 5'h19;
			ack_d_r <= 1'b1;
		end
		else if (CE_I)
		begin
			meta_r <= {PAR_IF.ack_n, PAR_IF.busy, PAR_IF.paper_out,
				PAR_IF.selected_status, PAR_IF.error_n};
			sync_r <= meta_r;
			ack_d_r <= sync_r[4];
		end
	end
	wire ack_fall = ack_d_r & ~sync_r[4];
	wire busy_s = sync_r[3];

	// ----------------------------------------------------------------
	// transfer sequencer
	// ----------------------------------------------------------------
	prtrx_hstate_type state_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] gap_r;
	logic ack_seen_r;
	logic strobe_n_r;
	logic init_n_r;
	logic [7:0] data_r;
	logic [3:0] stat_r;
	logic ctl_auto_n_r;
	logic ctl_sel_n_r;

	wire cnt_zero = (cnt_r == '0);
	// rate gap and busy both gate the next byte
	assign TX_READY_O = (state_r == HS_IDLE) & (gap_r == '0) & ~busy_s
		& ~INIT_REQ_I;

	// one process; every pin it drives is a flop
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			state_r <= HS_IDLE;
			cnt_r <= '0;
			gap_r <= '0;
			ack_seen_r <= 1'b0;
			strobe_n_r <= 1'b1;
			init_n_r <= 1'b1;
			data_r <= '0;
		end
		else if (CE_I)
		begin
			if (gap_r != '0)
				gap_r <= gap_r - 1'b1;
			if (!cnt_zero)
				cnt_r <= cnt_r - 1'b1;
			if (ack_fall)
				ack_seen_r <= 1'b1;
			case (state_r)
				HS_IDLE:
					if (INIT_REQ_I)
					begin
						init_n_r <= 1'b0;
						cnt_r <= CW'(INIT_CYC - 1);
						state_r <= HS_INIT;
					end
					else if (TX_VALID_I && TX_READY_O)
					begin
						data_r <= TX_DATA_I;
						cnt_r <= CW'(prtrx_pkg::SETUP_CYC - 1);
						gap_r <= CW'(BYTE_CYC - 1);
						ack_seen_r <= 1'b0;
						state_r <= HS_SETUP;
					end
				HS_SETUP:
					if (cnt_zero)
					begin
						strobe_n_r <= 1'b0;
						cnt_r <= CW'(prtrx_pkg::STROBE_CYC - 1);
						state_r <= HS_STROBE;
					end
				HS_STROBE:
					if (cnt_zero)
					begin
						strobe_n_r <= 1'b1;
						state_r <= HS_WAIT;
					end
				HS_WAIT:
					if ((ack_seen_r || ack_fall) && !busy_s)
						state_r <= HS_IDLE;
				HS_INIT:
					if (cnt_zero)
					begin
						init_n_r <= 1'b1;
						state_r <= HS_IDLE;
					end
				default:
					state_r <= HS_IDLE;
			endcase
		end
	end

	// control levels and status mirrors
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ctl_auto_n_r <= 1'b1;
			ctl_sel_n_r <= 1'b1;
			stat_r <= 4'h8;
		end
		else if (CE_I)
		begin
			ctl_auto_n_r <= ~AUTO_FEED_I;
			ctl_sel_n_r <= ~SELECT_I;
			stat_r <= {busy_s, sync_r[2], sync_r[1], ~sync_r[0]};
		end
	end

	assign PAR_IF.strobe_n = strobe_n_r;
	assign PAR_IF.data = data_r;
	assign PAR_IF.init_n = init_n_r;
	assign PAR_IF.auto_feed_n = ctl_auto_n_r;
	assign PAR_IF.select_input_n = ctl_sel_n_r;
	assign {BUSY_O, PAPER_OUT_O, SELECTED_O, ERROR_O} = stat_r;
endmodule

// ==== tb/prtrx_properties.sv ====
/*
 * concurrent checks on the printer link pins between the two ends.
 * assumes one clock, synchronous active-high reset, and that the
 * bench hands on the same byte spacing and init width as the host.
 */
`timescale 1ns/100ps
module prtrx_properties #(
	parameter int unsigned BYTE_CYC = 400,
	parameter int unsigned INIT_CYC = 20
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic strobe_n,
	input wire logic [7:0] data,
	input wire logic ack_n,
	input wire logic busy,
	input wire logic paper_out,
	input wire logic error_n,
	input wire logic init_n
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	// ------------------------------------------------------------
	// pulse width and spacing counters
	// ------------------------------------------------------------
	logic [15:0] ack_len_r;
	logic [15:0] str_len_r;
	logic [15:0] init_len_r;
	logic [31:0] gap_r;

	// each length counts sampled low cycles; gap saturates so the
	// first strobe after reset never looks too early
	always_ff @(posedge CLK_I)
	begin
		if (SYS_RST_I)
		begin
			ack_len_r <= 16'h0000;
			str_len_r <= 16'h0000;
			init_len_r <= 16'h0000;
			gap_r <= 32'hffffffff;
		end
		else
		begin
			ack_len_r <= ack_n ? 16'h0000 : ack_len_r + 16'h0001;
			str_len_r <= strobe_n ? 16'h0000 : str_len_r + 16'h0001;
			init_len_r <= init_n ? 16'h0000 : init_len_r + 16'h0001;
			gap_r <= $fell(strobe_n) ? 32'h00000001 :
				gap_r + 32'(gap_r != 32'hffffffff);
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_strobe_width: assert property ($rose(strobe_n) |->
		str_len_r == 16'(prtrx_pkg::STROBE_CYC))
		else $error("strobe low time wrong");
	a_data_held: assert property (!strobe_n |-> $stable(data))
		else $error("data moved under strobe");
	a_ack_width: assert property ($rose(ack_n) |->
		ack_len_r == 16'(prtrx_pkg::ACK_CYC))
		else $error("acknowledge width wrong");
	a_ack_follows: assert property ($fell(strobe_n) && !busy |->
		##[2:8] !ack_n)
		else $error("no acknowledge for byte");
	a_busy_in_ack: assert property (!ack_n |-> busy)
		else $error("busy low during acknowledge");
	a_busy_rises: assert property ($fell(strobe_n) && !busy |->
		##[1:6] busy)
		else $error("busy not raised on strobe");
	a_busy_drop: assert property ($fell(busy) |->
		strobe_n && ack_n)
		else $error("busy released too early");
	a_paper_error: assert property ($rose(paper_out) |->
		##[0:3] !error_n)
		else $error("error not shown for paper end");
	a_init_width: assert property ($rose(init_n) |->
		init_len_r == 16'(INIT_CYC))
		else $error("init pulse width wrong");
	a_pace_gap: assert property ($fell(strobe_n) |->
		gap_r >= BYTE_CYC)
		else $error("bytes sent too fast");
	a_strobe_idle: assert property ($fell(strobe_n) |-> !busy)
		else $error("strobe while printer busy");

	c_ack_done: cover property ($rose(ack_n));
	c_init_done: cover property ($rose(init_n));
	c_paper_end: cover property ($rose(paper_out));
endmodule

// ==== tb/prtrx_bench.sv ====
/*
 * self-checking bench: host end and printer end joined by the pin
 * bundle; drives the host user side and printer status inputs.
 * assumes shortened byte spacing and init width on the host.
 */
`timescale 1ns/100ps
module prtrx_bench;
	// longer than one acknowledge cycle, so the rate gap really paces
	localparam int unsigned BYTE_N = 1200;
	localparam int unsigned INIT_N = 20;
	logic CLK_I, SYS_RST_I, CE_I, GFX_MODEL_I, PAPER_EMPTY_I, ONLINE_I;
	logic FAULT_I, PRINTING_I, BYTE_VALID_O, BYTE_READY_I, CLEAR_O;
	logic CR_LF_O, FULL_LF_O, CANCEL_EN_O, DELETE_EN_O, BUZZER_EN_O;
	logic AUTO_LF_O, FORM_12IN_O, SPACE_8LPI_O, PERF_SKIP_O;
	logic TX_VALID_I, TX_READY_O, INIT_REQ_I, AUTO_FEED_I, SELECT_I;
	logic BUSY_O, PAPER_OUT_O, SELECTED_O, ERROR_O;
	logic [7:0] SW1_I, BYTE_DATA_O, TX_DATA_I;
	logic [3:0] SW2_I;
	int err_count, n_checks;

	// ------------------------------------------------------------
	// both ends and the checker on one link
	// ------------------------------------------------------------
	prtrx_if prtrx_if_i ();
	prtrx_dev prtrx_dev_i (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
		.CE_I(CE_I), .PAR_IF(prtrx_if_i.device), .SW1_I(SW1_I),
		.SW2_I(SW2_I), .GFX_MODEL_I(GFX_MODEL_I), .ONLINE_I(ONLINE_I),
		.PAPER_EMPTY_I(PAPER_EMPTY_I), .FAULT_I(FAULT_I),
		.PRINTING_I(PRINTING_I), .BYTE_DATA_O(BYTE_DATA_O),
		.BYTE_VALID_O(BYTE_VALID_O), .BYTE_READY_I(BYTE_READY_I),
		.CLEAR_O(CLEAR_O), .CR_LF_O(CR_LF_O), .FULL_LF_O(FULL_LF_O),
		.CANCEL_EN_O(CANCEL_EN_O), .DELETE_EN_O(DELETE_EN_O),
		.BUZZER_EN_O(BUZZER_EN_O), .AUTO_LF_O(AUTO_LF_O),
		.FORM_12IN_O(FORM_12IN_O), .SPACE_8LPI_O(SPACE_8LPI_O),
		.PERF_SKIP_O(PERF_SKIP_O));
	prtrx_host #(.BYTE_CYC(BYTE_N), .INIT_CYC(INIT_N)) prtrx_host_i (
		.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
		.PAR_IF(prtrx_if_i.host), .TX_DATA_I(TX_DATA_I),
		.TX_VALID_I(TX_VALID_I), .TX_READY_O(TX_READY_O),
		.INIT_REQ_I(INIT_REQ_I), .AUTO_FEED_I(AUTO_FEED_I),
		.SELECT_I(SELECT_I), .BUSY_O(BUSY_O), .PAPER_OUT_O(PAPER_OUT_O),
		.SELECTED_O(SELECTED_O), .ERROR_O(ERROR_O));
	prtrx_properties #(.BYTE_CYC(BYTE_N), .INIT_CYC(INIT_N))
		prtrx_properties_i (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
		.strobe_n(prtrx_if_i.strobe_n), .data(prtrx_if_i.data),
		.ack_n(prtrx_if_i.ack_n), .busy(prtrx_if_i.busy),
		.paper_out(prtrx_if_i.paper_out), .error_n(prtrx_if_i.error_n),
		.init_n(prtrx_if_i.init_n));

	// ------------------------------------------------------------
	// shared helpers
	// ------------------------------------------------------------
	// inputs always move 1 ns after the edge, never on it
	task tick();
		@(posedge CLK_I);
		#1;
	endtask
	task run(input int n);
		repeat (n) tick();
	endtask
	task test_done();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function logic pick(input int sel);
		case (sel)
			0: return TX_READY_O;
			1: return prtrx_if_i.ack_n;
			2: return CLEAR_O;
			default: return prtrx_if_i.init_n;
		endcase
	endfunction
	// bounded wait; a hang ends the run with a mismatch
	task await(input int sel, input logic v);
		int k;
		for (k = 0; k < 5000 && pick(sel) !== v; k++)
			tick();
		if (k == 5000)
		begin
			err_count++;
			$display("[FAIL] wait %0d expected %b seen timeout", sel, v);
			test_done();
		end
	endtask
	task send(input logic [7:0] b);
		TX_DATA_I = b;
		TX_VALID_I = 1'b1;
		await(0, 1'b1);
		tick();
		TX_VALID_I = 1'b0;
		await(1, 1'b0);
		await(1, 1'b1);
	endtask
	task pop();
		BYTE_READY_I = 1'b1;
		tick();
		BYTE_READY_I = 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_switch();
		int i;
		logic [7:0] s;
		logic [4:0] e5;
		logic [2:0] e3;
		for (i = 0; i < 4; i++)
		begin
			s = 8'(i * 21);
			SW1_I = s;
			SW2_I = i[0] ? 4'hb : {1'b0, i[1], 2'b00};
			GFX_MODEL_I = i[1];
			AUTO_FEED_I = i[0];
			run(10);
			e5 = {~s[1], ~s[2], ~s[3], ~s[4], s[5]};
			e3 = {3{i[1]}} & {SW2_I[0], SW2_I[1], SW2_I[3]};
			chk("bank1", 8'({CR_LF_O, FULL_LF_O, CANCEL_EN_O, DELETE_EN_O,
				BUZZER_EN_O}), 8'(e5));
			chk("bank2", 8'({FORM_12IN_O, SPACE_8LPI_O,
				PERF_SKIP_O}), 8'(e3));
			chk("autolf", 8'(AUTO_LF_O), 8'(SW2_I[2] | i[0]));
			// logical not: a bitwise one would widen before inverting
			chk("afpin", 8'(prtrx_if_i.auto_feed_n), 8'(!i[0]));
		end
		{SW1_I, SW2_I, GFX_MODEL_I, AUTO_FEED_I} = 14'h0000;
	endtask

	// one blocking condition at a time: paper, offline, fault, printing
	task t_status();
		int k;
		logic [3:0] v;
		for (k = 0; k < 4; k++)
		begin
			v = 4'h1 << k;
			{PAPER_EMPTY_I, FAULT_I, PRINTING_I} = {v[0], v[2], v[3]};
			ONLINE_I = ~v[1];
			run(12);
			chk("paper", 8'(prtrx_if_i.paper_out), 8'(v[0]));
			chk("hpaper", 8'(PAPER_OUT_O), 8'(v[0]));
			chk("sel", 8'(prtrx_if_i.selected_status), 8'(!v[1]));
			chk("error", 8'(prtrx_if_i.error_n), 8'(v[3]));
			chk("herror", 8'(ERROR_O), 8'(!v[3]));
			if (k > 0)
			begin
				chk("busy", 8'(prtrx_if_i.busy), 8'h01);
				chk("hbusy", 8'(BUSY_O), 8'h01);
			end
		end
		{PAPER_EMPTY_I, FAULT_I, PRINTING_I, ONLINE_I} = 4'h1;
		run(12);
	endtask

	// clock enable low must hold the status pins where they were
	task t_freeze();
		CE_I = 1'b0;
		PAPER_EMPTY_I = 1'b1;
		run(12);
		chk("frozen", 8'(prtrx_if_i.paper_out), 8'h00);
		CE_I = 1'b1;
		run(12);
		chk("thawed", 8'(prtrx_if_i.paper_out), 8'h01);
		PAPER_EMPTY_I = 1'b0;
		run(12);
	endtask

	task t_select();
		SELECT_I = 1'b0;
		run(12);
		chk("selpin", 8'(prtrx_if_i.select_input_n), 8'h01);
		chk("seloff", 8'(prtrx_if_i.selected_status), 8'h00);
		chk("selbusy", 8'(prtrx_if_i.busy), 8'h01);
		SW1_I = 8'h80;
		run(12);
		chk("selfix", 8'(SELECTED_O), 8'h01);
		send(8'h96);
		chk("fixbyte", BYTE_DATA_O, 8'h96);
		pop();
		SELECT_I = 1'b1;
		SW1_I = 8'h00;
		run(12);
	endtask

	task t_init();
		send(8'hc3);
		chk("head", BYTE_DATA_O, 8'hc3);
		chk("valid", 8'(BYTE_VALID_O), 8'h01);
		INIT_REQ_I = 1'b1;
		await(3, 1'b0);
		INIT_REQ_I = 1'b0;
		await(2, 1'b1);
		await(2, 1'b0);
		chk("cleared", 8'(BYTE_VALID_O), 8'h00);
	endtask

	// fill the buffer until the link refuses, then drain with stalls
	task t_fill();
		int i;
		for (i = 0; i < 32; i++)
			send(8'(i * 37 + 1));
		run(20);
		chk("fullbusy", 8'(prtrx_if_i.busy), 8'h01);
		TX_DATA_I = 8'hee;
		TX_VALID_I = 1'b1;
		run(300);
		chk("refused", 8'(TX_READY_O), 8'h00);
		chk("noack", 8'(prtrx_if_i.ack_n), 8'h01);
		TX_VALID_I = 1'b0;
		for (i = 0; i < 32; i++)
		begin
			run(2);
			chk("order", BYTE_DATA_O, 8'(i * 37 + 1));
			pop();
		end
		chk("empty", 8'(BYTE_VALID_O), 8'h00);
	endtask

	// ------------------------------------------------------------
	// clock and main sequence
	// ------------------------------------------------------------
	initial
	begin
		CLK_I = 1'b0;
		forever #2.5 CLK_I = ~CLK_I;
	end

	initial
	begin
		{SYS_RST_I, CE_I, ONLINE_I, SELECT_I} = 4'hf;
		{GFX_MODEL_I, PAPER_EMPTY_I, FAULT_I, PRINTING_I} = 4'h0;
		{BYTE_READY_I, TX_VALID_I, INIT_REQ_I, AUTO_FEED_I} = 4'h0;
		{SW1_I, SW2_I, TX_DATA_I} = 20'h00000;
		err_count = 0;
		n_checks = 0;
		repeat (8) @(posedge CLK_I);
		#1;
		SYS_RST_I = 1'b0;
		run(20);
		t_switch();
		t_status();
		t_freeze();
		t_select();
		t_init();
		t_fill();
		test_done();
	end
endmodule
